// ### inc/dsc_pkg.sv
package dsc_pkg;

	// ----------------------------------------
	// register map and field positions
	// ----------------------------------------
	localparam logic [5:0] DSC_STATUS_ADDR = 6'h04; // device_state_flags
	localparam logic [5:0] DSC_CONTROL_ADDR = 6'h05; // device_mode_control
	localparam int DSC_ST_EVENT_BIT = 0; // function_event_flag
	localparam int DSC_ST_ERROR_BIT = 4; // function_error_flag
	localparam int DSC_ST_NACK_BIT = 7; // bus_nack_error_flag
	localparam int DSC_CT_RESET_BIT = 0;
	localparam int DSC_CT_SHUT_BIT = 1;
	localparam int DSC_CT_LOWP_BIT = 2; // reduced_power_select
	localparam int DSC_CT_FEN_BIT = 4; // measure_function_enable
	localparam logic [7:0] DSC_STATUS_RST = 8'h00;
	localparam logic [15:0] DSC_CONTROL_RST = 16'h0000;
	localparam logic [3:0] DSC_FUNC_TYPE = 4'h1; // function_type_code, binary 0001

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int DSC_CLK_NS = 50;
	localparam int DSC_RST_TIME_NS = 200; // least length of a device reset operation
	localparam int DSC_RST_CYCLES = (DSC_RST_TIME_NS + DSC_CLK_NS - 1) / DSC_CLK_NS;
	localparam int DSC_CONV_TIME_US = 100; // conversion tick period in active mode
	localparam int DSC_CONV_CYCLES = (DSC_CONV_TIME_US * 1000) / DSC_CLK_NS;
	localparam int DSC_LOWP_FACTOR = 4; // low-power mode runs four times slower

	// ----------------------------------------
	// reset operation states
	// ----------------------------------------
	typedef enum logic [1:0]
	{
		DSC_RS_IDLE = 2'b01,
		DSC_RS_BUSY = 2'b10
	} dsc_rst_state_t;

endpackage

// ### logic/dsc_rst_seq.sv
module dsc_rst_seq
	import dsc_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic start_i,
	output logic busy_o
);

	dsc_rst_state_t state_q;
	logic [3:0] cnt_q;

	// ----------------------------------------
	// device reset operation: hold busy for a fixed count
	// ----------------------------------------
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			state_q <= DSC_RS_IDLE;
			cnt_q <= 4'h0;
		end
		else
		begin
			unique case (state_q)
				DSC_RS_IDLE:
				begin
					if (start_i)
					begin
						state_q <= DSC_RS_BUSY;
						cnt_q <= 4'(DSC_RST_CYCLES - 1);
					end
				end
				DSC_RS_BUSY:
				begin
					if (cnt_q == 4'h0)
						state_q <= DSC_RS_IDLE; // operation finished
					else
						cnt_q <= cnt_q - 4'h1;
				end
				default:
					state_q <= DSC_RS_IDLE;
			endcase
		end
	end

	// the busy code's own bit, so the output comes straight from its flop
	assign busy_o = state_q[1];

endmodule

// ### logic/dsc_conv_div.sv
module dsc_conv_div
	import dsc_pkg::*;
#(
	parameter int CONV_CYCLES = DSC_CONV_CYCLES
)
(
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic run_i,
	input wire logic slow_i,
	output logic tick_o
);

	logic [15:0] cnt_q;
	logic [15:0] last_w;
	logic tick_q;

	// period end: four times longer in low-power mode
	assign last_w = slow_i ? 16'(CONV_CYCLES * DSC_LOWP_FACTOR - 1) : 16'(CONV_CYCLES - 1);

	// ----------------------------------------
	// conversion tick divider, frozen and cleared while not running
	// ----------------------------------------
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			cnt_q <= 16'h0000;
			tick_q <= 1'b0;
		end
		else if (!run_i)
		begin
			cnt_q <= 16'h0000;
			tick_q <= 1'b0;
		end
		else if (cnt_q >= last_w)
		begin
			cnt_q <= 16'h0000;
			tick_q <= 1'b1;
		end
		else
		begin
			cnt_q <= cnt_q + 16'h0001;
			tick_q <= 1'b0;
		end
	end

	assign tick_o = tick_q;

endmodule

// ### logic/dsc_regs.sv
// Notes on behaviour
// - a device reset returns status and control registers to all zero.
// - a function event sets status bit 0.
// - event flag holds until device reset or the result is read.
// - status bit 4 sets on a function error; cleared by reset or result read.
// - status bits 3..1 and 6..5 always read zero.
// - status bit 7 sets when a transaction ends with a not-acknowledge.
// - bit 7 clears on device reset or on a non-broadcast status read with no new nack in that cycle.
// - control register accepts broadcast writes as well as own-number writes.
// - a broadcast write changes only control bits 1 and 0.
// - writing 1 to control bit 0 starts a device reset operation.
// - control bit 0 clears itself when the reset operation ends.
// - shutdown bit stops all functions, lowest-power state.
// - low-power bit slows functions and lowers the conversion rate.
// - control bit 4 enables the measurement function; default disabled.
// - function registers stay accessible while the function is disabled.
// - control bit 3 and bits 15..5 always read zero.
// - measurement function reports type code binary 0001.
// - device reset aborts work, restarts, and loads all defaults.
// - reading the result register clears event and error flags.
// - a new result before the old is read sets the error flag.
module dsc_regs
	import dsc_pkg::*;
#(
	parameter int CONV_CYCLES = DSC_CONV_CYCLES
)
(
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic [5:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic reg_bcast_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic bus_nack_i,
	input wire logic func_event_i,
	input wire logic func_error_i,
	input wire logic result_read_i,
	output logic [15:0] reg_rdata_o,
	output logic reg_hit_o,
	output logic dev_reset_o,
	output logic func_enable_o,
	output logic func_run_o,
	output logic shutdown_o,
	output logic reduced_power_o,
	output logic conv_tick_o,
	output logic [3:0] function_type_code_o
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic rst_busy;
	logic rst_start;
	logic ctrl_wr;
	logic stat_rd;
	logic run_w;
	logic evt_q;
	logic err_q;
	logic ber_q;
	logic shut_q;
	logic lowp_q;
	logic fen_q;
	logic run_q;
	logic redp_q;
	logic hit_q;
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;
	logic [7:0] status_w;
	logic [15:0] control_w;
	logic [3:0] type_q;
	logic [15:0] gap_q;

	// ----------------------------------------
	// access decode
	// ----------------------------------------
	// own-number and broadcast writes both reach the control register
	assign ctrl_wr = reg_wr_i && (reg_addr_i == DSC_CONTROL_ADDR);
	assign stat_rd = reg_rd_i && (reg_addr_i == DSC_STATUS_ADDR) && !reg_bcast_i;
	assign rst_start = ctrl_wr && reg_wdata_i[DSC_CT_RESET_BIT] && !rst_busy;
	// function runs only when enabled and not shut down
	assign run_w = fen_q && !shut_q && !rst_busy;

	// ----------------------------------------
	// device reset operation
	// ----------------------------------------
	dsc_rst_seq u_rst_seq
	(
		.core_clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.start_i(rst_start),
		.busy_o(rst_busy)
	);

	// ----------------------------------------
	// conversion rate divider
	// ----------------------------------------
	dsc_conv_div #(
		.CONV_CYCLES(CONV_CYCLES)
	) u_conv_div
	(
		.core_clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.run_i(run_w),
		.slow_i(lowp_q && !shut_q),
		.tick_o(conv_tick_o)
	);

	// ----------------------------------------
	// status flags
	// ----------------------------------------
	// event flag: set wins over the clear from a result read
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			evt_q <= 1'b0;
		else if (rst_busy)
			evt_q <= 1'b0;
		else if (func_event_i)
			evt_q <= 1'b1;
		else if (result_read_i)
			evt_q <= 1'b0;
	end

	// error flag: function error or overrun of an unread result
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			err_q <= 1'b0;
		else if (rst_busy)
			err_q <= 1'b0;
		else if (func_error_i || (func_event_i && evt_q && !result_read_i))
			err_q <= 1'b1;
		else if (result_read_i)
			err_q <= 1'b0;
	end

	// bus error flag: cleared by reading status, a new nack wins
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			ber_q <= 1'b0;
		else if (rst_busy)
			ber_q <= 1'b0;
		else if (bus_nack_i)
			ber_q <= 1'b1;
		else if (stat_rd)
			ber_q <= 1'b0;
	end

	// ----------------------------------------
	// control fields
	// ----------------------------------------
	// shutdown takes broadcast and own writes alike
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			shut_q <= 1'b0;
		else if (rst_busy)
			shut_q <= 1'b0;
		else if (ctrl_wr && !rst_start)
			shut_q <= reg_wdata_i[DSC_CT_SHUT_BIT];
	end

	// upper fields keep their value under a broadcast write
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			lowp_q <= 1'b0;
			fen_q <= 1'b0;
		end
		else if (rst_busy)
		begin
			lowp_q <= 1'b0;
			fen_q <= 1'b0;
		end
		else if (ctrl_wr && !reg_bcast_i && !rst_start)
		begin
			lowp_q <= reg_wdata_i[DSC_CT_LOWP_BIT];
			fen_q <= reg_wdata_i[DSC_CT_FEN_BIT];
		end
	end

	// ----------------------------------------
	// register images
	// ----------------------------------------
	always_comb
	begin
		status_w = DSC_STATUS_RST;
		status_w[DSC_ST_EVENT_BIT] = evt_q;
		status_w[DSC_ST_ERROR_BIT] = err_q;
		status_w[DSC_ST_NACK_BIT] = ber_q;
	end

	always_comb
	begin
		control_w = DSC_CONTROL_RST;
		control_w[DSC_CT_RESET_BIT] = rst_busy;
		control_w[DSC_CT_SHUT_BIT] = shut_q;
		control_w[DSC_CT_LOWP_BIT] = lowp_q;
		control_w[DSC_CT_FEN_BIT] = fen_q;
	end

	always_comb
	begin
		rdata_d = 16'h0000;
		if (reg_addr_i == DSC_STATUS_ADDR)
			rdata_d = {8'h00, status_w};
		else if (reg_addr_i == DSC_CONTROL_ADDR)
			rdata_d = control_w;
	end

	// ----------------------------------------
	// read port, answered one cycle after the strobe
	// ----------------------------------------
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rdata_q <= 16'h0000;
			hit_q <= 1'b0;
		end
		else if (reg_rd_i && !reg_bcast_i)
		begin
			rdata_q <= rdata_d;
			hit_q <= (reg_addr_i == DSC_STATUS_ADDR) || (reg_addr_i == DSC_CONTROL_ADDR);
		end
		else
			hit_q <= 1'b0;
	end

	// ----------------------------------------
	// mode outputs
	// ----------------------------------------
	// function register access is never gated by these levels
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			run_q <= 1'b0;
			redp_q <= 1'b0;
			type_q <= 4'h0;
		end
		else
		begin
			run_q <= run_w;
			redp_q <= lowp_q && !shut_q;
			type_q <= DSC_FUNC_TYPE;
		end
	end

	// ----------------------------------------
	// rate check helper: cycles since the last tick while running
	// ----------------------------------------
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			gap_q <= 16'h0000;
		else if (conv_tick_o || !run_w)
			gap_q <= 16'h0000;
		else
			gap_q <= gap_q + 16'h0001;
	end

	assign reg_rdata_o = rdata_q;
	assign reg_hit_o = hit_q;
	assign dev_reset_o = rst_busy;
	assign func_enable_o = fen_q;
	assign func_run_o = run_q;
	assign shutdown_o = shut_q;
	assign reduced_power_o = redp_q;
	assign function_type_code_o = type_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);

	status_reserved_a: assert property (stat_rd |=> (reg_rdata_o & 16'hff6e) == 16'h0000)
		else $error("status reserved bits not zero");
	event_set_a: assert property (func_event_i && !rst_busy |=> evt_q)
		else $error("event flag not set");
	event_hold_a: assert property (evt_q && !result_read_i && !rst_busy |=> evt_q)
		else $error("event flag lost");
	overrun_err_a: assert property (func_event_i && evt_q && !result_read_i && !rst_busy
		|=> err_q)
		else $error("overrun not flagged");
	nack_set_a: assert property (bus_nack_i && !rst_busy && !rst_start
		|=> ber_q ##1 (ber_q || $past(stat_rd)))
		else $error("bus error flag not set");
	nack_clear_a: assert property (stat_rd && !bus_nack_i && !rst_busy |=> !ber_q)
		else $error("bus error flag not cleared by read");
	bcast_keep_a: assert property (ctrl_wr && reg_bcast_i && !rst_busy
		|=> $stable(lowp_q) && $stable(fen_q))
		else $error("broadcast write changed upper bits");
	reset_start_a: assert property (rst_start |=> rst_busy [*4] ##1 !rst_busy)
		else $error("reset operation length wrong");
	reset_defaults_a: assert property (rst_busy |=> !shut_q && !lowp_q && !fen_q
		&& !evt_q && !err_q && !ber_q)
		else $error("defaults not loaded by device reset");
	shut_stop_a: assert property (shut_q |=> !conv_tick_o && !func_run_o)
		else $error("function runs in shutdown");
	type_code_a: assert property ($past(resetn_i) |-> function_type_code_o == 4'h1)
		else $error("wrong function type code");
	ctrl_reserved_a: assert property (reg_rd_i && !reg_bcast_i
		&& reg_addr_i == DSC_CONTROL_ADDR |=> (reg_rdata_o & 16'hffe8) == 16'h0000)
		else $error("control reserved bits not zero");

	// ----------------------------------------
	// flag clears, field writes, levels and tick rate
	// ----------------------------------------
	error_set_a: assert property (func_error_i && !rst_busy |=> err_q)
		else $error("error flag not set");
	error_hold_a: assert property (err_q && !result_read_i && !rst_busy |=> err_q)
		else $error("error flag lost");
	event_clear_a: assert property (result_read_i && !func_event_i && !rst_busy
		|=> !evt_q)
		else $error("event flag not cleared by result read");
	error_clear_a: assert property (result_read_i && !func_error_i && !rst_busy
		|=> !err_q)
		else $error("error flag not cleared by result read");
	shut_set_a: assert property (ctrl_wr && !rst_start && !rst_busy
		&& reg_wdata_i[DSC_CT_SHUT_BIT] |=> shut_q)
		else $error("shutdown bit not written");
	shut_clear_a: assert property (ctrl_wr && !rst_start && !rst_busy
		&& !reg_wdata_i[DSC_CT_SHUT_BIT] |=> !shut_q)
		else $error("shutdown bit not cleared");
	fen_write_a: assert property (ctrl_wr && !reg_bcast_i && !rst_start && !rst_busy
		&& reg_wdata_i[DSC_CT_FEN_BIT] |=> fen_q)
		else $error("enable bit not written");
	lowp_level_a: assert property (lowp_q && !shut_q |=> reduced_power_o)
		else $error("reduced power level missing");
	run_level_a: assert property (fen_q && !shut_q && !rst_busy |=> func_run_o)
		else $error("function not running while enabled");
	status_image_a: assert property (stat_rd
		|=> reg_rdata_o[7:0] == {$past(ber_q), 2'b00, $past(err_q), 3'b000, $past(evt_q)})
		else $error("status read image wrong");
	reset_bit_a: assert property (reg_rd_i && !reg_bcast_i && rst_busy
		&& reg_addr_i == DSC_CONTROL_ADDR |=> reg_rdata_o[DSC_CT_RESET_BIT])
		else $error("reset bit not shown while busy");
	tick_rate_a: assert property (conv_tick_o |-> gap_q >= 16'(CONV_CYCLES - 1))
		else $error("conversion ticks too close");

	bcast_write_c: cover property (ctrl_wr && reg_bcast_i ##1 shut_q);
	dev_reset_c: cover property (rst_start ##5 !rst_busy);
	overrun_c: cover property (func_event_i && evt_q && !result_read_i);
	lowp_tick_c: cover property (reduced_power_o && conv_tick_o);
	nack_read_c: cover property (stat_rd && ber_q);

endmodule

// ### bench/dsc_master_model.sv
module dsc_master_model
(
	input wire logic core_clk_i,
	output logic [5:0] reg_addr_o,
	output logic reg_wr_o,
	output logic reg_rd_o,
	output logic reg_bcast_o,
	output logic [15:0] reg_wdata_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------
	// idle bus; no reset command is sent after power-up
	// ----------------------------------------
	initial
	begin
		reg_addr_o = 6'h3f;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_bcast_o = 1'b0;
		reg_wdata_o = 16'h5a5a;
	end

	// one decoded transaction, strobe high for one cycle
	task automatic xfer(input logic wr, input logic bc, input logic [5:0] addr,
		input logic [15:0] data);
		@(negedge core_clk_i);
		reg_addr_o = addr;
		reg_wdata_o = data;
		reg_bcast_o = bc;
		reg_wr_o = wr;
		reg_rd_o = !wr;
		@(negedge core_clk_i);
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_bcast_o = 1'b0;
		reg_addr_o = ~addr; // released lines do not keep the last value
		reg_wdata_o = ~data;
	endtask
endmodule

// ### bench/testbench.sv
module testbench
	import dsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int CONV = 8;
	logic core_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [3:0] sb = 4'h0;
	wire logic [5:0] reg_addr;
	wire logic reg_wr, reg_rd, reg_bcast;
	wire logic [15:0] reg_wdata;
	logic [15:0] reg_rdata_o;
	logic [3:0] function_type_code_o;
	logic reg_hit_o, dev_reset_o, func_enable_o, func_run_o;
	logic shutdown_o, reduced_power_o, conv_tick_o;
	logic [15:0] expq[$];
	logic [31:0] seed = 32'd25097;
	int bad_count = 0;
	int total_checks = 0;
	int ticks = 0, seen = 0;
	int cycles = 0;

	// ----------------------------------------
	// clock, partner, design
	// ----------------------------------------
	always #25 core_clk_i = ~core_clk_i;

	dsc_master_model i_mst (.core_clk_i(core_clk_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr),
		.reg_rd_o(reg_rd), .reg_bcast_o(reg_bcast), .reg_wdata_o(reg_wdata));

	dsc_regs #(.CONV_CYCLES(CONV)) i_dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
		.reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_bcast_i(reg_bcast),
		.reg_wdata_i(reg_wdata), .bus_nack_i(sb[3]), .func_error_i(sb[2]),
		.func_event_i(sb[1]), .result_read_i(sb[0]), .reg_rdata_o(reg_rdata_o),
		.reg_hit_o(reg_hit_o), .dev_reset_o(dev_reset_o), .func_enable_o(func_enable_o),
		.func_run_o(func_run_o), .shutdown_o(shutdown_o), .reduced_power_o(reduced_power_o),
		.conv_tick_o(conv_tick_o), .function_type_code_o(function_type_code_o));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// a mapped read notes its expected word for the monitor
	task automatic rd(input logic [5:0] addr, input logic [15:0] exp);
		expq.push_back(exp);
		i_mst.xfer(1'b0, 1'b0, addr, 16'h0000);
	endtask

	task automatic pulse(input logic [3:0] v);
		@(negedge core_clk_i);
		sb = v;
		@(negedge core_clk_i);
		sb = 4'h0;
	endtask

	task automatic count_ticks(output int n);
		n = ticks;
		repeat (64) @(negedge core_clk_i);
		n = ticks - n;
	endtask

	// ----------------------------------------
	// monitor, tick counter, watchdog
	// ----------------------------------------
	always @(negedge core_clk_i)
	begin
		ticks <= ticks + int'(conv_tick_o === 1'b1);
		if (reg_hit_o === 1'b1)
		begin
			if (expq.size() == 0)
				chk(16'hdead, 16'h0000);
			else
				chk(reg_rdata_o, expq.pop_front());
		end
	end

	always @(posedge core_clk_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			bad_count++;
			summarize();
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		repeat (2) @(posedge core_clk_i);
		@(negedge core_clk_i);
		resetn_i = 1'b1;
		@(negedge core_clk_i);
		chk(16'(function_type_code_o), 16'h0001);
		rd(DSC_STATUS_ADDR, 16'h0000);
		rd(DSC_CONTROL_ADDR, 16'h0000);
		i_mst.xfer(1'b1, 1'b0, DSC_CONTROL_ADDR, 16'h0014);
		repeat (2) @(negedge core_clk_i);
		chk(16'({func_enable_o, reduced_power_o, func_run_o}), 16'h0007);
		count_ticks(seen);
		chk(16'(seen >= 1 && seen <= 2), 16'h0001);
		i_mst.xfer(1'b1, 1'b0, DSC_CONTROL_ADDR, 16'h0010);
		count_ticks(seen);
		chk(16'(seen >= 7 && seen <= 8), 16'h0001);
		i_mst.xfer(1'b1, 1'b0, DSC_CONTROL_ADDR, 16'hfffe);
		rd(DSC_CONTROL_ADDR, 16'h0016);
		count_ticks(seen);
		chk(16'(seen), 16'h0000);
		chk(16'({shutdown_o, reduced_power_o, func_run_o}), 16'h0004);
		i_mst.xfer(1'b1, 1'b1, DSC_CONTROL_ADDR, 16'h0000);
		rd(DSC_CONTROL_ADDR, 16'h0014);
		i_mst.xfer(1'b1, 1'b1, DSC_CONTROL_ADDR, 16'h0002);
		rd(DSC_CONTROL_ADDR, 16'h0016);
		pulse(4'h2);
		rd(DSC_STATUS_ADDR, 16'h0001);
		rd(DSC_STATUS_ADDR, 16'h0001);
		pulse(4'h2);
		rd(DSC_STATUS_ADDR, 16'h0011);
		pulse(4'h1);
		rd(DSC_STATUS_ADDR, 16'h0000);
		pulse(4'h4);
		rd(DSC_STATUS_ADDR, 16'h0010);
		pulse(4'h9);
		i_mst.xfer(1'b0, 1'b1, DSC_STATUS_ADDR, 16'h0000);
		@(negedge core_clk_i);
		chk(16'(reg_hit_o), 16'h0000);
		rd(DSC_STATUS_ADDR, 16'h0080);
		rd(DSC_STATUS_ADDR, 16'h0000);
		repeat (4)
		begin
			seed = xs(seed);
			i_mst.xfer(1'b1, 1'b0, DSC_CONTROL_ADDR, seed[15:0] & 16'hfffe);
			rd(DSC_CONTROL_ADDR, seed[15:0] & 16'h0016);
			i_mst.xfer(1'b0, 1'b0, (seed[21:17] == 5'h02) ? 6'h3f : seed[21:16], 16'h0000);
			@(negedge core_clk_i);
			chk({reg_rdata_o[14:0], reg_hit_o}, 16'h0000);
		end
		pulse(4'hb);
		i_mst.xfer(1'b1, 1'b0, DSC_CONTROL_ADDR, 16'h0015);
		rd(DSC_CONTROL_ADDR, 16'h0001);
		@(negedge core_clk_i);
		chk(16'(dev_reset_o), 16'h0001);
		for (int i = 0; i < 10 && dev_reset_o !== 1'b0; i++)
			@(negedge core_clk_i);
		chk(16'({dev_reset_o, func_enable_o, shutdown_o}), 16'h0000);
		rd(DSC_CONTROL_ADDR, 16'h0000);
		rd(DSC_STATUS_ADDR, 16'h0000);
		repeat (3) @(negedge core_clk_i);
		chk(16'(expq.size()), 16'h0000);
		summarize();
	end
endmodule
